// [port_pin_mux.sv]
// open-drain parallel port block: led port, two quad ports, dual port, alias bits
// assumes pins arrive synchronous to clk_sys and an external pad resolves open drain
//
// The register addresses and the APB register port were chosen for this implementation.
module port_pin_mux (
    input  wire logic        clk_sys,
    input  wire logic        rst,
    input  wire logic        ce,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [13:0] pin_in,
    output logic      [13:0] pin_out,
    output logic      [13:0] pin_oe_n,
    output logic      [13:0] pullup_en,
    input  wire logic        timer1_uf,
    input  wire logic        timer2_uf,
    input  wire logic        ram_backup,
    output logic             skip,
    output logic             ext_irq,
    output logic             timer2_evt_clk,
    output logic             analog_sel0,
    output logic             analog_sel1,
    output logic             wake_req
);
    typedef struct packed {
        port_pkg::apb_state_t apb;
        logic [31:0]          rdata;
        logic                 ready;
        logic                 slverr;
        logic [3:0]           led_lat;
        logic [3:0]           q0_lat;
        logic [3:0]           q1_lat;
        logic [1:0]           dual_lat;
        logic [13:0]          pu;
        logic [13:0]          wk;
        logic [6:0]           ctrl;
        logic                 tog;
        logic [13:0]          pin_in_r;
        logic [13:0]          oe_n;
        logic                 skip;
        logic                 irq;
        logic                 evt;
        logic                 wake;
    } state_t;

    state_t s_r;
    state_t s_nxt;

    // address decode shared by the error answer and the write path
    function automatic logic is_mapped(input logic [7:0] a);
        case (a)
            port_pkg::OFS_LED,
            port_pkg::OFS_QUAD0,
            port_pkg::OFS_QUAD1,
            port_pkg::OFS_DUAL,
            port_pkg::OFS_PIN_IN,
            port_pkg::OFS_PULLUP,
            port_pkg::OFS_WAKE,
            port_pkg::OFS_CTRL,
            port_pkg::OFS_ALIAS: is_mapped = 1'b1;
            default:             is_mapped = 1'b0;
        endcase
    endfunction

    function automatic logic [31:0] read_word(input state_t s, input logic [7:0] a);
        case (a)
            port_pkg::OFS_LED:    read_word = {28'h0000000, s.led_lat};
            port_pkg::OFS_QUAD0:  read_word = {28'h0000000, s.q0_lat};
            port_pkg::OFS_QUAD1:  read_word = {28'h0000000, s.q1_lat};
            port_pkg::OFS_DUAL:   read_word = {30'h0, s.dual_lat};
            port_pkg::OFS_PIN_IN: read_word = {18'h0, s.pin_in_r};
            port_pkg::OFS_PULLUP: read_word = {18'h0, s.pu};
            port_pkg::OFS_WAKE:   read_word = {18'h0, s.wk};
            port_pkg::OFS_CTRL:   read_word = {25'h0, s.ctrl};
            port_pkg::OFS_ALIAS:  read_word = {30'h0, s.led_lat[3:2]};
            default:              read_word = 32'h00000000;
        endcase
    endfunction

    logic        wr_go;
    logic [13:0] lat_all;
    logic        tsel_uf;

    always_comb begin
        s_nxt   = s_r;
        wr_go   = 1'b0;
        lat_all = 14'h0000;
        tsel_uf = 1'b0;
        // apb: setup cycle loads the answer, access phase completes in one cycle
        case (s_r.apb)
            port_pkg::APB_IDLE: begin
                s_nxt.ready  = 1'b0;
                s_nxt.slverr = 1'b0;
                if (psel && !penable) begin
                    s_nxt.apb    = port_pkg::APB_RESP;
                    s_nxt.ready  = 1'b1;
                    s_nxt.slverr = ~is_mapped(paddr);
                    s_nxt.rdata  = pwrite ? 32'h00000000 : read_word(s_r, paddr);
                end
            end
            port_pkg::APB_RESP: begin
                if (psel && penable) begin
                    wr_go        = pwrite && is_mapped(paddr);
                    s_nxt.apb    = port_pkg::APB_IDLE;
                    s_nxt.ready  = 1'b0;
                    s_nxt.slverr = 1'b0;
                end
            end
            default: begin
                s_nxt.apb   = port_pkg::APB_IDLE;
                s_nxt.ready = 1'b0;
            end
        endcase

        if (wr_go) begin
            case (paddr)
                port_pkg::OFS_LED:    s_nxt.led_lat = pwdata[3:0];
                port_pkg::OFS_QUAD0:  s_nxt.q0_lat = pwdata[3:0];
                port_pkg::OFS_QUAD1:  s_nxt.q1_lat = pwdata[3:0];
                port_pkg::OFS_DUAL:   s_nxt.dual_lat = pwdata[1:0];
                // led bits 0 and 1 have no options, so their enables stay zero
                port_pkg::OFS_PULLUP: s_nxt.pu = pwdata[13:0] & port_pkg::OPT_MASK;
                port_pkg::OFS_WAKE:   s_nxt.wk = pwdata[13:0] & port_pkg::OPT_MASK;
                port_pkg::OFS_CTRL:   s_nxt.ctrl = pwdata[6:0];
                port_pkg::OFS_ALIAS:  s_nxt.led_lat[3:2] = pwdata[1:0];
                default: ;
            endcase
        end

        // timer output: divide the selected underflow by two
        tsel_uf = s_r.ctrl[port_pkg::CTRL_TSEL] ? timer2_uf : timer1_uf;
        if (s_r.ctrl[port_pkg::CTRL_TOUT_EN] && tsel_uf) begin
            s_nxt.tog = ~s_r.tog;
        end

        // a zero latch drives low; a one releases the pin
        lat_all = {s_nxt.dual_lat, s_nxt.q1_lat, s_nxt.q0_lat, s_nxt.led_lat};
        s_nxt.oe_n = lat_all;
        // timer output shares the pin latch: it only pulls low if the latch is one
        if (s_nxt.ctrl[port_pkg::CTRL_TOUT_EN]) begin
            s_nxt.oe_n[port_pkg::TIMER_IO_IDX] = lat_all[port_pkg::TIMER_IO_IDX] & s_nxt.tog;
        end

        // input path is never cut off by a shared function
        s_nxt.pin_in_r = pin_in;
        s_nxt.skip = ~pin_in[s_r.ctrl[port_pkg::CTRL_SKIP_LO +: 2]];
        s_nxt.evt  = pin_in[port_pkg::TIMER_IO_IDX];
        s_nxt.irq  = s_r.ctrl[port_pkg::CTRL_IRQ_GATE] & pin_in[port_pkg::EXT_IRQ_IDX];
        // wakeup covers the interrupt pin too through its own enable bit
        s_nxt.wake = ram_backup & (|(s_r.wk & ~pin_in));
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s_r          <= '0;
            s_r.apb      <= port_pkg::APB_IDLE;
            s_r.led_lat  <= port_pkg::LATCH4_RST;
            s_r.q0_lat   <= port_pkg::LATCH4_RST;
            s_r.q1_lat   <= port_pkg::LATCH4_RST;
            s_r.dual_lat <= port_pkg::LATCH2_RST;
            s_r.pu       <= port_pkg::OPT_RST;
            s_r.wk       <= port_pkg::OPT_RST;
            s_r.ctrl     <= port_pkg::CTRL_RST;
            s_r.oe_n     <= 14'h3fff;
            s_r.pin_in_r <= 14'h3fff;
            s_r.tog      <= 1'b1;
        end else if (ce) begin
            s_r <= s_nxt;
        end
    end

    assign prdata         = s_r.rdata;
    assign pready         = s_r.ready;
    assign pslverr        = s_r.slverr;
    assign pin_out        = 14'h0000;
    assign pin_oe_n       = s_r.oe_n;
    assign pullup_en      = s_r.pu;
    assign skip           = s_r.skip;
    assign ext_irq        = s_r.irq;
    assign timer2_evt_clk = s_r.evt;
    assign analog_sel0    = s_r.ctrl[port_pkg::CTRL_ANA_EN0];
    assign analog_sel1    = s_r.ctrl[port_pkg::CTRL_ANA_EN1];
    assign wake_req       = s_r.wake;

    // checks
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    open_drain_only_a: assert property (pin_out == 14'h0000 && pullup_en[1:0] == 2'b00)
        else $error("pin driven high or led low bits got pull-up");
    led_latch_drive_a: assert property (ce && wr_go && paddr == port_pkg::OFS_LED
        |=> pin_oe_n[3:0] == $past(pwdata[3:0]))
        else $error("led latch write did not reach the pin enables");
    alias_shares_a: assert property (ce && wr_go && paddr == port_pkg::OFS_ALIAS
        |=> pin_oe_n[3:2] == $past(pwdata[1:0]) && pin_oe_n[1:0] == $past(pin_oe_n[1:0]))
        else $error("alias write did not land on led bits 2 and 3");
    skip_follows_a: assert property (ce |=> skip == ~$past(pin_in[s_r.ctrl[5:4]]))
        else $error("skip does not mirror the selected led pin");
    irq_gate_off_a: assert property (ce && !s_r.ctrl[port_pkg::CTRL_IRQ_GATE]
        |=> !ext_irq)
        else $error("interrupt passed while gate bit clear");
    timer_toggle_a: assert property (ce && s_r.ctrl[0] && (s_r.ctrl[1] ? timer2_uf : timer1_uf)
        |=> s_r.tog != $past(s_r.tog))
        else $error("timer pin did not toggle on underflow");
    timer_read_a: assert property (ce && s_r.ctrl[port_pkg::CTRL_TOUT_EN]
        |=> s_r.pin_in_r[10] == $past(pin_in[10]) && timer2_evt_clk == $past(pin_in[10]))
        else $error("timer pin input lost while output active");
    wake_raise_a: assert property (ce && ram_backup && (|(s_r.wk & ~pin_in))
        |=> wake_req)
        else $error("wakeup not raised by low enabled pin");
    apb_answer_a: assert property (psel && !penable && !pready && ce
        |=> pready ##1 !pready)
        else $error("apb answer not one cycle after setup");

    // shared-function inputs: each is registered one cycle behind its pin, the interrupt also gated by CTRL_IRQ_GATE
    evt_follows_a: assert property (ce |=> timer2_evt_clk == $past(pin_in[10]))
        else $error("event clock does not follow the timer pin");

    irq_follows_a: assert property (ce |=> ext_irq == $past(s_r.ctrl[3] & pin_in[11]))
        else $error("interrupt output does not follow the gated pin");

    pin_sample_a: assert property (ce |=> s_r.pin_in_r == $past(pin_in))
        else $error("pin input register lost a sample");

    irq_wake_a: assert property (ce && ram_backup && s_r.wk[11] && !pin_in[11]
        |=> wake_req)
        else $error("interrupt pin wakeup not raised");

    // wakeup is a level, never held over once back-up ends
    wake_idle_a: assert property (ce && !ram_backup |=> !wake_req)
        else $error("wakeup raised outside back-up");

    wake_mask_a: assert property (s_r.wk[1:0] == 2'b00)
        else $error("wakeup enable set on a led pin without options");

    // latch writes reach their pin enables at the write edge, all but pin 10 while the timer output is on
    quad0_latch_a: assert property (ce && wr_go && paddr == port_pkg::OFS_QUAD0
        |=> pin_oe_n[7:4] == $past(pwdata[3:0]))
        else $error("quad zero write did not reach the pins");

    quad1_latch_a: assert property (ce && wr_go && paddr == port_pkg::OFS_QUAD1
        |=> pin_oe_n[9:8] == $past(pwdata[1:0]) && pin_oe_n[11] == $past(pwdata[3]))
        else $error("quad one write did not reach the pins");

    dual_latch_a: assert property (ce && wr_go && paddr == port_pkg::OFS_DUAL
        |=> pin_oe_n[13:12] == $past(pwdata[1:0]))
        else $error("dual write did not reach the pins");

    analog_write_a: assert property (ce && wr_go && paddr == port_pkg::OFS_CTRL
        |=> analog_sel0 == $past(pwdata[2]) && analog_sel1 == $past(pwdata[6]))
        else $error("analog selects do not follow the control write");

    pullup_write_a: assert property (ce && wr_go && paddr == port_pkg::OFS_PULLUP
        |=> pullup_en == ($past(pwdata[13:0]) & 14'h3ffc))
        else $error("pull-up write landed wrongly");

    wake_write_a: assert property (ce && wr_go && paddr == port_pkg::OFS_WAKE
        |=> s_r.wk == ($past(pwdata[13:0]) & 14'h3ffc))
        else $error("wakeup write landed wrongly");

    // static pin picture: latches show on the enables, pin 10 only while the timer output is off
    led_oe_match_a: assert property (pin_oe_n[3:0] == s_r.led_lat)
        else $error("led enables differ from the latches");

    port_oe_match_a: assert property (pin_oe_n[7:4] == s_r.q0_lat
        && pin_oe_n[13:12] == s_r.dual_lat)
        else $error("quad zero or dual enables differ from the latches");

    timer_off_pin_a: assert property (!s_r.ctrl[0] |-> pin_oe_n[10] == s_r.q1_lat[2])
        else $error("timer pin not following its latch");

    timer_pin_a: assert property (s_r.ctrl[0] |-> pin_oe_n[10] == (s_r.q1_lat[2] & s_r.tog))
        else $error("timer pin not showing the toggle");

    tog_hold_a: assert property (ce && !(s_r.ctrl[0] && (s_r.ctrl[1] ? timer2_uf : timer1_uf))
        |=> s_r.tog == $past(s_r.tog))
        else $error("timer toggle moved without an underflow");

    // bus answers
    unmapped_err_a: assert property (ce && psel && !penable && s_r.apb == port_pkg::APB_IDLE
        && !is_mapped(paddr) |=> pready && pslverr)
        else $error("unmapped access not refused");

    alias_read_a: assert property (ce && psel && !penable && !pwrite
        && s_r.apb == port_pkg::APB_IDLE && paddr == port_pkg::OFS_ALIAS
        |=> prdata == {30'h0, $past(s_r.led_lat[3:2])})
        else $error("alias read differs from led bits 2 and 3");

    ready_once_a: assert property (ce && pready && psel && penable |=> !pready)
        else $error("ready held past the access phase");

    write_rdata_a: assert property (ce && psel && !penable && pwrite
        && s_r.apb == port_pkg::APB_IDLE |=> prdata == 32'h00000000)
        else $error("write answer carried read data");

    // a low clock enable must freeze everything, the bus answer included
    ce_freeze_a: assert property (!ce |=> s_r == $past(s_r))
        else $error("state moved while clock enable low");

    write_cov: cover property (wr_go && ce);
    read_cov:  cover property (pready && psel && !pwrite);
    tog_cov:   cover property (ce && s_r.ctrl[0] && timer1_uf);
    wake_cov:  cover property (wake_req);
endmodule

// [port_pkg.sv]
// constants for the open-drain port and pin multiplexing block
// assumes an apb master with 32-bit data and one clock for everything
package port_pkg;
    // pin vector layout: led 0-3, quad zero 4-7, quad one 8-11, dual 12-13
    localparam int          PIN_W         = 14;
    localparam int          LED_LO        = 0;
    localparam int          Q0_LO         = 4;
    localparam int          Q1_LO         = 8;
    localparam int          DUAL_LO       = 12;
    localparam int          TIMER_IO_IDX  = 10;
    localparam int          EXT_IRQ_IDX   = 11;
    localparam int          ANALOG0_IDX   = 12;
    localparam int          ANALOG1_IDX   = 13;
    // only these pins own pull-up and wakeup enables
    localparam logic [13:0] OPT_MASK      = 14'h3ffc;

    // register byte offsets
    localparam logic [7:0]  OFS_LED       = 8'h00;
    localparam logic [7:0]  OFS_QUAD0     = 8'h04;
    localparam logic [7:0]  OFS_QUAD1     = 8'h08;
    localparam logic [7:0]  OFS_DUAL      = 8'h0c;
    localparam logic [7:0]  OFS_PIN_IN    = 8'h10;
    localparam logic [7:0]  OFS_PULLUP    = 8'h14;
    localparam logic [7:0]  OFS_WAKE      = 8'h18;
    localparam logic [7:0]  OFS_CTRL      = 8'h1c;
    localparam logic [7:0]  OFS_ALIAS     = 8'h20;

    // control register fields
    localparam int          CTRL_TOUT_EN  = 0;
    localparam int          CTRL_TSEL     = 1;
    localparam int          CTRL_ANA_EN0  = 2;
    localparam int          CTRL_IRQ_GATE = 3;
    localparam int          CTRL_SKIP_LO  = 4;
    localparam int          CTRL_ANA_EN1  = 6;
    localparam int          CTRL_W        = 7;

    // values after reset: latches released, options off
    localparam logic [3:0]  LATCH4_RST    = 4'hf;
    localparam logic [1:0]  LATCH2_RST    = 2'h3;
    localparam logic [13:0] OPT_RST       = 14'h0000;
    localparam logic [6:0]  CTRL_RST      = 7'h00;

    typedef enum logic [1:0] {
        APB_IDLE = 2'b00,
        APB_RESP = 2'b01
    } apb_state_t;
endpackage

// [port_pads.sv]
// board model for the port pins: open-drain wires, external pull-ups and keys
// assumes the block drives pin_out/pin_oe_n and the bench presses keys
module port_pads (
    input  wire logic        clk_sys,
    input  wire logic [13:0] pin_out,
    input  wire logic [13:0] pin_oe_n,
    input  wire logic [13:0] pullup_en,
    input  wire logic [13:0] board_pu,
    input  wire logic [13:0] key_low,
    output logic      [13:0] pin_in
);
    timeunit 1ns;
    timeprecision 1ps;
    // an unpulled released pin floats: show a changing level, not a stale one
    logic [13:0] float_r = 14'h0000;
    always @(posedge clk_sys) float_r <= ~float_r;
    // wired-and: a low latch or a pressed key wins over any pull-up
    assign pin_in = (~pin_oe_n & pin_out)
                  | (pin_oe_n & ~key_low & (pullup_en | board_pu | float_r));
endmodule

// [port_pin_mux_tb.sv]
// self-checking bench for the open-drain port block, driven over apb
// assumes the board model port_pads closes the loop from pin_oe_n to pin_in
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
    $display("unexpected at %0t: got %h exp %h", $time, g, e); end end
module port_pin_mux_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, psel, penable, pwrite, pready, pslverr;
    logic        timer1_uf, timer2_uf, ram_backup, skip, ext_irq;
    logic        timer2_evt_clk, analog_sel0, analog_sel1, wake_req;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [13:0] pin_in, pin_out, pin_oe_n, pullup_en, key_low;
    logic        e, ce;
    int          n_errors, checks_done, cycles;

    port_pin_mux u_port_pin_mux (.clk_sys(clk_sys), .rst(rst), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe_n(pin_oe_n), .pullup_en(pullup_en),
        .timer1_uf(timer1_uf), .timer2_uf(timer2_uf), .ram_backup(ram_backup),
        .skip(skip), .ext_irq(ext_irq), .timer2_evt_clk(timer2_evt_clk),
        .analog_sel0(analog_sel0), .analog_sel1(analog_sel1), .wake_req(wake_req));
    // leds 0 and 1 have no on-chip pull-up, so the board supplies one
    port_pads u_port_pads (.clk_sys(clk_sys), .pin_out(pin_out), .pin_oe_n(pin_oe_n),
        .pullup_en(pullup_en), .board_pu(14'h0003), .key_low(key_low), .pin_in(pin_in));

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    task automatic conclude();
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            conclude();
        end
    end

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
        #1;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        `CHK(e, 1'b0)
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(r, x)
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    task automatic pulse(input logic sel);
        @(posedge clk_sys);
        if (sel) timer2_uf <= 1'b1; else timer1_uf <= 1'b1;
        @(posedge clk_sys);
        timer1_uf <= 1'b0; timer2_uf <= 1'b0;
        wait_n(2);
    endtask

    initial begin
        rst = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = 8'h00;
        pwdata = 32'h0; timer1_uf = 1'b0; timer2_uf = 1'b0; ram_backup = 1'b0;
        key_low = 14'h0000; n_errors = 0; checks_done = 0; cycles = 0; ce = 1'b1;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        rd(8'h00, 32'hf); rd(8'h04, 32'hf); rd(8'h08, 32'hf); rd(8'h0c, 32'h3);
        rd(8'h1c, 32'h0); rd(8'h14, 32'h0);
        `CHK(pin_oe_n, 14'h3fff)
        wr(8'h14, 32'hffffffff);
        rd(8'h14, 32'h3ffc);
        `CHK(pullup_en, 14'h3ffc)
        wait_n(2);
        `CHK(ext_irq, 1'b0)
        wr(8'h00, 32'ha);
        `CHK(pin_oe_n[3:0], 4'ha)
        wr(8'h20, 32'h1);
        rd(8'h00, 32'h6); rd(8'h20, 32'h1);
        rd(8'h10, 32'h3ff6);
        wr(8'h04, 32'h5);
        `CHK(pin_oe_n[7:4], 4'h5)
        key_low <= 14'h0010;
        rd(8'h10, 32'h3f46);
        wr(8'h1c, 32'h20);
        wait_n(2);
        `CHK(skip, 1'b0)
        key_low <= 14'h0004;
        wait_n(3);
        `CHK(skip, 1'b1)
        key_low <= 14'h0000;
        wr(8'h1c, 32'h4d);
        wait_n(2);
        `CHK({analog_sel1, analog_sel0, ext_irq}, 3'h7)
        key_low <= 14'h0800;
        wait_n(3);
        `CHK(ext_irq, 1'b0)
        key_low <= 14'h0000;
        wr(8'h0c, 32'h1);
        `CHK(pin_oe_n[13:12], 2'h1)
        `CHK(pin_oe_n[10], 1'b1)
        pulse(1'b0);
        `CHK(pin_oe_n[10], 1'b0)
        `CHK(timer2_evt_clk, 1'b0)
        wr(8'h1c, 32'h4f);
        pulse(1'b0);
        `CHK(pin_oe_n[10], 1'b0)
        pulse(1'b1);
        `CHK(pin_oe_n[10], 1'b1)
        wr(8'h1c, 32'h48);
        key_low <= 14'h0400;
        wait_n(3);
        `CHK(timer2_evt_clk, 1'b0)
        key_low <= 14'h0000;
        wait_n(3);
        `CHK(timer2_evt_clk, 1'b1)
        // clock enable low: the pin change must not be seen until it rises
        ce <= 1'b0;
        key_low <= 14'h0400;
        wait_n(3);
        `CHK(timer2_evt_clk, 1'b1)
        ce <= 1'b1;
        wait_n(3);
        `CHK(timer2_evt_clk, 1'b0)
        key_low <= 14'h0000;
        wr(8'h18, 32'h13);
        rd(8'h18, 32'h10);
        ram_backup <= 1'b1;
        key_low <= 14'h0010;
        wait_n(3);
        `CHK(wake_req, 1'b1)
        ram_backup <= 1'b0;
        wait_n(3);
        `CHK(wake_req, 1'b0)
        // reset in mid-run brings latches and control back
        @(posedge clk_sys);
        rst <= 1'b1;
        wait_n(2);
        @(posedge clk_sys);
        rst <= 1'b0;
        wait_n(1);
        `CHK(pin_oe_n, 14'h3fff)
        rd(8'h1c, 32'h0);
        apb(1'b0, 8'h24, 32'h0);
        `CHK({e, r}, {1'b1, 32'h0})
        conclude();
    end
endmodule
